// >>> include/occ_pkg.sv
// constants and bus carriers for the oscillator clock control block
package occ_pkg;
  localparam int unsigned MCLK_HZ          = 10_000_000;
  localparam int unsigned LOWCLK_HZ        = 50_000;
  localparam int unsigned LOWCLK_HALF_CYC  = MCLK_HZ / (2 * LOWCLK_HZ);
  localparam int unsigned LOWCLK_CNT_W     = $clog2(LOWCLK_HALF_CYC);

  // register indices; byte address is four times the index
  localparam logic [7:0]  CFG2_IDX         = 8'h00;
  localparam logic [7:0]  STAT_IDX         = 8'h01;
  localparam logic [7:0]  PULLUP_IDX       = 8'h0d;
  localparam logic [9:0]  CFG2_ADDR        = {CFG2_IDX, 2'b00};
  localparam logic [9:0]  STAT_ADDR        = {STAT_IDX, 2'b00};
  localparam logic [9:0]  PULLUP_ADDR      = {PULLUP_IDX, 2'b00};

  localparam int unsigned CFG2_STOPDIS_BIT = 0;
  localparam int unsigned PULLUP_PSEL_BIT  = 6;
  localparam logic        CFG2_STOPDIS_RST = 1'b0;
  localparam logic        PULLUP_PSEL_RST  = 1'b0;

  localparam int unsigned ST_OSCILLATOR_TYPE_SELECT_BIT    = 0;
  localparam int unsigned ST_XTALEN_BIT    = 1;
  localparam int unsigned ST_RCEN_BIT      = 2;
  localparam int unsigned ST_LOWRUN_BIT    = 3;
  localparam int unsigned ST_WAIT_BIT      = 4;
  localparam int unsigned ST_BREAK_BIT     = 5;
  localparam int unsigned ST_STOP_BIT      = 6;
  localparam int unsigned ST_KBI_BIT       = 7;

  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } occ_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } occ_axi_rsp_t;
endpackage : occ_pkg

// >>> rtl/occ_top.sv
// oscillator clock control: source gating, rate division, low clock and register slave
`timescale 1ns/100ps

// Summary of operation
// - a free-running low clock of about 50 kHz is made from the system clock for the watchdog and the integration unit.
// - the low clock runs after any reset and stops in stop mode only if the stop-disable bit was set at stop entry.
// - crystal mode drives the inverted input onto the output pin, rc mode drives the rc clock there or frees the pin for port use.
// - the crystal clock is passed on at full rate, with no promise about duty cycle or stability at start-up.
// - the full-rate output follows the selected source clock.
// - the half-rate output toggles on every rising edge of the full-rate output.
// - wait mode leaves all three clock outputs running.
// - stop mode disables the selected source and with it the full-rate and half-rate outputs.
// - the stop-disable bit is clear after reset so the low clock keeps running through stop by default.
// - the break state leaves all three clock outputs running.
// - the option bit selects crystal at 1 and rc at 0 and is not touched by reset.
// - crystal and rc oscillator are never enabled together.
module occ_top (
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire logic                 osc_input_pin,
  input  wire logic                 oscillator_type_select,
  input  wire logic                 osc_enable_from_sysint,
  input  wire logic                 stop_mode,
  input  wire logic                 wait_mode,
  input  wire logic                 break_state,
  input  wire logic                 osc_output_pin_i,
  output logic                      osc_output_pin_o,
  output logic                      osc_output_pin_oe,
  output logic                      keyboard_irq_six,
  output logic                      full_rate_osc_out,
  output logic                      half_rate_osc_out,
  output logic                      internal_low_freq_clock,
  output logic                      xtal_amp_enable,
  output logic                      rc_osc_enable,
  input  wire occ_pkg::occ_axi_req_t axi_req,
  output occ_pkg::occ_axi_rsp_t      axi_rsp
);
  import occ_pkg::*;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // pin synchronisers; stage one is read only by stage two
  logic [1:0] osc_in_sync_ff;
  logic [1:0] pin_sync_ff;
  logic [1:0] sel_sync_ff;
  logic       src_clk;
  logic       pin_in;
  logic       osc_sel;

  always_ff @(posedge mclk)
  begin
    osc_in_sync_ff <= {osc_in_sync_ff[0], osc_input_pin};
    pin_sync_ff    <= {pin_sync_ff[0], osc_output_pin_i};
    sel_sync_ff    <= {sel_sync_ff[0], oscillator_type_select};
  end

  assign src_clk = osc_in_sync_ff[1];
  assign pin_in  = pin_sync_ff[1];
  assign osc_sel = sel_sync_ff[1];

  // software-visible control bits
  logic stop_dis_ff;
  logic nxt_stop_dis;
  logic port_sel_ff;
  logic nxt_port_sel;

  // source gating and division
  logic enable_eff;
  logic full_ff;
  logic nxt_full;
  logic half_ff;
  logic nxt_half;
  logic xtal_en_ff;
  logic nxt_xtal_en;
  logic rc_en_ff;
  logic nxt_rc_en;
  logic pin_o_ff;
  logic nxt_pin_o;
  logic pin_oe_ff;
  logic nxt_pin_oe;
  logic kbi_ff;
  logic nxt_kbi;

  // wait and break are deliberately absent from the gate
  assign enable_eff = osc_enable_from_sysint & ~stop_mode;

  always_comb
  begin
    nxt_xtal_en = osc_sel & enable_eff;
    nxt_rc_en   = ~osc_sel & enable_eff;
    // once disabled, a high phase is let run to its natural end, then the output stays low
    nxt_full    = src_clk & (enable_eff | full_ff);
    nxt_half    = (nxt_full & ~full_ff) ? ~half_ff : half_ff;
    if (osc_sel)
    begin
      nxt_pin_o  = xtal_en_ff & ~src_clk;
      nxt_pin_oe = 1'b1;
      nxt_kbi    = 1'b0;
    end
    else if (!port_sel_ff)
    begin
      nxt_pin_o  = rc_en_ff & src_clk;
      nxt_pin_oe = 1'b1;
      nxt_kbi    = 1'b0;
    end
    else
    begin
      nxt_pin_o  = 1'b0;
      nxt_pin_oe = 1'b0;
      nxt_kbi    = pin_in;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      full_ff    <= 1'b0;
      half_ff    <= 1'b0;
      xtal_en_ff <= 1'b0;
      rc_en_ff   <= 1'b0;
      pin_o_ff   <= 1'b0;
      pin_oe_ff  <= 1'b0;
      kbi_ff     <= 1'b0;
    end
    else
    begin
      full_ff    <= nxt_full;
      half_ff    <= nxt_half;
      xtal_en_ff <= nxt_xtal_en;
      rc_en_ff   <= nxt_rc_en;
      pin_o_ff   <= nxt_pin_o;
      pin_oe_ff  <= nxt_pin_oe;
      kbi_ff     <= nxt_kbi;
    end
  end

  // low clock: the stop-disable bit counts only as it stood when stop began
  logic                    stop_d_ff;
  logic                    stop_lat_ff;
  logic                    nxt_stop_lat;
  logic                    lowclk_run;
  logic                    low_ff;
  logic                    nxt_low;
  logic [LOWCLK_CNT_W-1:0] cnt_ff;
  logic [LOWCLK_CNT_W-1:0] nxt_cnt;

  always_comb
  begin
    nxt_stop_lat = (stop_mode & ~stop_d_ff) ? stop_dis_ff : stop_lat_ff;
    lowclk_run   = ~(stop_mode & nxt_stop_lat);
    nxt_cnt      = cnt_ff;
    nxt_low      = low_ff;
    if (lowclk_run)
    begin
      if (cnt_ff == LOWCLK_CNT_W'(LOWCLK_HALF_CYC - 1))
      begin
        nxt_cnt = '0;
        nxt_low = ~low_ff;
      end
      else
      begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      stop_d_ff   <= 1'b0;
      stop_lat_ff <= 1'b0;
      cnt_ff      <= '0;
      low_ff      <= 1'b0;
    end
    else
    begin
      stop_d_ff   <= stop_mode;
      stop_lat_ff <= nxt_stop_lat;
      cnt_ff      <= nxt_cnt;
      low_ff      <= nxt_low;
    end
  end

  // axi4-lite slave; address and data may arrive in either order
  logic         aw_got_ff;
  logic         nxt_aw_got;
  logic         w_got_ff;
  logic         nxt_w_got;
  logic [9:0]   waddr_ff;
  logic [9:0]   nxt_waddr;
  logic [31:0]  wdata_ff;
  logic [31:0]  nxt_wdata;
  logic         wstrb0_ff;
  logic         nxt_wstrb0;
  occ_axi_rsp_t rsp_ff;
  occ_axi_rsp_t nxt_rsp;
  logic [31:0]  status_word;

  function automatic logic addr_mapped(input logic [9:0] a);
    addr_mapped = (a == CFG2_ADDR) || (a == STAT_ADDR) || (a == PULLUP_ADDR);
  endfunction : addr_mapped

  always_comb
  begin
    status_word                = '0;
    status_word[ST_OSCILLATOR_TYPE_SELECT_BIT] = osc_sel;
    status_word[ST_XTALEN_BIT] = xtal_en_ff;
    status_word[ST_RCEN_BIT]   = rc_en_ff;
    status_word[ST_LOWRUN_BIT] = lowclk_run;
    status_word[ST_WAIT_BIT]   = wait_mode;
    status_word[ST_BREAK_BIT]  = break_state;
    status_word[ST_STOP_BIT]   = stop_mode;
    status_word[ST_KBI_BIT]    = kbi_ff;
  end

  always_comb
  begin
    nxt_rsp      = rsp_ff;
    nxt_aw_got   = aw_got_ff;
    nxt_w_got    = w_got_ff;
    nxt_waddr    = waddr_ff;
    nxt_wdata    = wdata_ff;
    nxt_wstrb0   = wstrb0_ff;
    nxt_stop_dis = stop_dis_ff;
    nxt_port_sel = port_sel_ff;
    if (axi_req.awvalid && rsp_ff.awready)
    begin
      nxt_aw_got = 1'b1;
      nxt_waddr  = axi_req.awaddr[9:0];
    end
    if (axi_req.wvalid && rsp_ff.wready)
    begin
      nxt_w_got  = 1'b1;
      nxt_wdata  = axi_req.wdata;
      nxt_wstrb0 = axi_req.wstrb[0];
    end
    if (aw_got_ff && w_got_ff)
    begin
      nxt_aw_got    = 1'b0;
      nxt_w_got     = 1'b0;
      nxt_rsp.bvalid = 1'b1;
      nxt_rsp.bresp  = addr_mapped(waddr_ff) ? RESP_OKAY : RESP_SLVERR;
      if (wstrb0_ff && waddr_ff == CFG2_ADDR)
      begin
        nxt_stop_dis = wdata_ff[CFG2_STOPDIS_BIT];
      end
      if (wstrb0_ff && waddr_ff == PULLUP_ADDR)
      begin
        nxt_port_sel = wdata_ff[PULLUP_PSEL_BIT];
      end
    end
    if (rsp_ff.bvalid && axi_req.bready)
    begin
      nxt_rsp.bvalid = 1'b0;
    end
    nxt_rsp.awready = ~nxt_aw_got & ~nxt_rsp.bvalid & ~(axi_req.awvalid & rsp_ff.awready);
    nxt_rsp.wready  = ~nxt_w_got & ~nxt_rsp.bvalid & ~(axi_req.wvalid & rsp_ff.wready);
    if (axi_req.arvalid && rsp_ff.arready)
    begin
      nxt_rsp.rvalid  = 1'b1;
      nxt_rsp.rresp   = addr_mapped(axi_req.araddr[9:0]) ? RESP_OKAY : RESP_SLVERR;
      nxt_rsp.rdata   = '0;
      case (axi_req.araddr[9:0])
        CFG2_ADDR:   nxt_rsp.rdata[CFG2_STOPDIS_BIT] = stop_dis_ff;
        STAT_ADDR:   nxt_rsp.rdata = status_word;
        PULLUP_ADDR: nxt_rsp.rdata[PULLUP_PSEL_BIT] = port_sel_ff;
        default:     nxt_rsp.rdata = '0;
      endcase
    end
    else if (rsp_ff.rvalid && axi_req.rready)
    begin
      nxt_rsp.rvalid  = 1'b0;
    end
    // ready for a new address whenever no read data waits, from the first clock after reset is released
    nxt_rsp.arready = ~nxt_rsp.rvalid;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      aw_got_ff   <= 1'b0;
      w_got_ff    <= 1'b0;
      waddr_ff    <= '0;
      wdata_ff    <= '0;
      wstrb0_ff   <= 1'b0;
      rsp_ff      <= '0;
      stop_dis_ff <= CFG2_STOPDIS_RST;
      port_sel_ff <= PULLUP_PSEL_RST;
    end
    else
    begin
      aw_got_ff   <= nxt_aw_got;
      w_got_ff    <= nxt_w_got;
      waddr_ff    <= nxt_waddr;
      wdata_ff    <= nxt_wdata;
      wstrb0_ff   <= nxt_wstrb0;
      rsp_ff      <= nxt_rsp;
      stop_dis_ff <= nxt_stop_dis;
      port_sel_ff <= nxt_port_sel;
    end
  end

  assign axi_rsp                 = rsp_ff;
  assign full_rate_osc_out       = full_ff;
  assign half_rate_osc_out       = half_ff;
  assign internal_low_freq_clock = low_ff;
  assign xtal_amp_enable         = xtal_en_ff;
  assign rc_osc_enable           = rc_en_ff;
  assign osc_output_pin_o        = pin_o_ff;
  assign osc_output_pin_oe       = pin_oe_ff;
  assign keyboard_irq_six        = kbi_ff;

  lowclk_period_a: assert property ($changed(low_ff) |-> $past(cnt_ff) == LOWCLK_CNT_W'(LOWCLK_HALF_CYC - 1))
    else $error("low clock toggled off its half period");
  lowclk_stop_a: assert property ((stop_mode && !stop_d_ff && stop_dis_ff) ##1 stop_mode |-> $stable(low_ff))
    else $error("low clock moved in stop with disable set");
  lowclk_free_a: assert property ((!stop_mode && !sys_rst) |=> cnt_ff != $past(cnt_ff))
    else $error("low clock halted outside stop");
  pin_mode_a: assert property ((!osc_sel && port_sel_ff) ##1 (!osc_sel) |-> !pin_oe_ff && !pin_o_ff)
    else $error("pin driven while given to port use");
  xtal_pin_a: assert property ((osc_sel && xtal_en_ff) ##1 osc_sel |-> pin_oe_ff && pin_o_ff == !$past(src_clk))
    else $error("crystal pin not the inverted input");
  full_follow_a: assert property (enable_eff |=> full_ff == $past(src_clk))
    else $error("full-rate output not following source");
  half_div_a: assert property ($rose(full_ff) |-> half_ff != $past(half_ff))
    else $error("half-rate did not toggle on full-rate rise");
  half_hold_a: assert property (!$rose(full_ff) |-> $stable(half_ff))
    else $error("half-rate toggled without full-rate rise");
  stop_off_a: assert property ((stop_mode && !full_ff) [*2] |-> !full_ff && !xtal_en_ff && !rc_en_ff)
    else $error("source still running in stop");
  one_osc_a: assert property (!(xtal_en_ff && rc_en_ff))
    else $error("both oscillators enabled");
  sel_xtal_a: assert property ((osc_sel && enable_eff) |=> xtal_en_ff)
    else $error("crystal not enabled when selected");
  no_runt_a: assert property ($rose(full_ff) |-> $past(enable_eff))
    else $error("full-rate pulse began while disabled");
  stopdis_rst_a: assert property ($past(sys_rst) |-> !stop_dis_ff)
    else $error("stop-disable bit not clear after reset");

  stop_entry_c: cover property (stop_mode && !stop_d_ff ##1 stop_mode [*3]);
  rc_port_c: cover property (!osc_sel && port_sel_ff && kbi_ff);
  half_run_c: cover property ($rose(half_ff) ##[1:20] $fell(half_ff));
  axi_write_c: cover property (rsp_ff.bvalid && axi_req.bready);
endmodule : occ_top

// >>> test/occ_sysint_model.sv
// integration unit and watchdog side model: source clock, mode levels, bus divider
`timescale 1ns/100ps
module occ_sysint_model (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic cmd_en,
  input  wire logic cmd_stop,
  input  wire logic cmd_wait,
  input  wire logic cmd_brk,
  input  wire logic src_run,
  input  wire logic src_lvl,
  input  wire logic half_rate_osc_out,
  output logic      osc_input_pin,
  output logic      osc_enable_from_sysint,
  output logic      stop_mode,
  output logic      wait_mode,
  output logic      break_state,
  output logic      bus_clk
);
  logic [1:0] ph_ff;
  logic       half_d_ff;
  assign osc_enable_from_sysint = cmd_en;
  assign stop_mode              = cmd_stop;
  assign wait_mode              = cmd_wait;
  assign break_state            = cmd_brk;
  // source period is 8 mclk so the two-flop sync in front never aliases it
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ph_ff         <= 2'h0;
      osc_input_pin <= 1'b0;
      half_d_ff     <= 1'b0;
      bus_clk       <= 1'b0;
    end
    else
    begin
      ph_ff     <= ph_ff + 2'h1;
      half_d_ff <= half_rate_osc_out;
      if (!src_run)
        osc_input_pin <= src_lvl;
      else if (ph_ff == 2'h3)
        osc_input_pin <= ~osc_input_pin;
      if (half_rate_osc_out && !half_d_ff)
        bus_clk <= ~bus_clk;
    end
  end
endmodule : occ_sysint_model

// >>> test/oscillator_clock_control_tb.sv
// self-checking bench for the oscillator clock control block
`timescale 1ns/100ps
module oscillator_clock_control_tb;
  import occ_pkg::*;
  logic         mclk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         type_sel, cmd_en, cmd_stop, cmd_wait, cmd_brk, src_run, src_lvl, ext_lvl;
  logic         osc_in, en, stp, wt, brk, pin_o, pin_oe, kbi, full, half, lowclk, xen, rcen, bus_clk;
  wire logic    pin_i = pin_oe ? pin_o : ext_lvl;
  occ_axi_req_t axi_req;
  occ_axi_rsp_t axi_rsp;
  logic [31:0]  d;
  logic [1:0]   r;
  int           f, h, b, p;
  int           n_mismatch = 0;
  int           checks_done = 0;

  always #50 mclk = ~mclk;

  occ_sysint_model PARTNER (.mclk(mclk), .sys_rst(sys_rst), .cmd_en(cmd_en), .cmd_stop(cmd_stop),
    .cmd_wait(cmd_wait), .cmd_brk(cmd_brk), .src_run(src_run), .src_lvl(src_lvl), .half_rate_osc_out(half),
    .osc_input_pin(osc_in), .osc_enable_from_sysint(en), .stop_mode(stp), .wait_mode(wt), .break_state(brk),
    .bus_clk(bus_clk));
  occ_top DUT (.mclk(mclk), .sys_rst(sys_rst), .osc_input_pin(osc_in), .oscillator_type_select(type_sel),
    .osc_enable_from_sysint(en), .stop_mode(stp), .wait_mode(wt), .break_state(brk), .osc_output_pin_i(pin_i),
    .osc_output_pin_o(pin_o), .osc_output_pin_oe(pin_oe), .keyboard_irq_six(kbi), .full_rate_osc_out(full),
    .half_rate_osc_out(half), .internal_low_freq_clock(lowclk), .xtal_amp_enable(xen), .rc_osc_enable(rcen),
    .axi_req(axi_req), .axi_rsp(axi_rsp));

  task automatic check_bit(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit

  task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : check_word

  task automatic check_range(input string nm, input int lo, input int hi, input int g);
    checks_done++;
    if (g < lo || g > hi)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : check_range

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // outputs are read right after the edge, before the design's updates land
  task automatic axi_write(input logic [31:0] a, input logic [31:0] wd, output logic [1:0] rs);
    logic aw, w;
    @(posedge mclk);
    axi_req.awaddr  <= a;
    axi_req.wdata   <= wd;
    axi_req.wstrb   <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid  <= 1'b1;
    axi_req.bready  <= 1'b1;
    aw = 1'b1;
    w  = 1'b1;
    forever
    begin
      @(posedge mclk);
      if (!aw && !w && axi_rsp.bvalid === 1'b1)
        break;
      if (aw && axi_rsp.awready === 1'b1)
      begin
        aw = 1'b0;
        axi_req.awvalid <= 1'b0;
      end
      if (w && axi_rsp.wready === 1'b1)
      begin
        w = 1'b0;
        axi_req.wvalid <= 1'b0;
      end
    end
    rs = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a, output logic [31:0] rd, output logic [1:0] rs);
    logic ar;
    @(posedge mclk);
    axi_req.araddr  <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready  <= 1'b1;
    ar = 1'b1;
    forever
    begin
      @(posedge mclk);
      if (!ar && axi_rsp.rvalid === 1'b1)
        break;
      if (ar && axi_rsp.arready === 1'b1)
      begin
        ar = 1'b0;
        axi_req.arvalid <= 1'b0;
      end
    end
    rd = axi_rsp.rdata;
    rs = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask : axi_read

  task automatic do_reset;
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : do_reset

  task automatic count_edges(input int n);
    logic pf, ph, pb;
    f = 0;
    h = 0;
    b = 0;
    {pf, ph, pb} = {full, half, bus_clk};
    repeat (n)
    begin
      @(posedge mclk);
      if (full === 1'b1 && pf === 1'b0) f++;
      if (half === 1'b1 && ph === 1'b0) h++;
      if (bus_clk === 1'b1 && pb === 1'b0) b++;
      {pf, ph, pb} = {full, half, bus_clk};
    end
  endtask : count_edges

  // edges between two changes of the low clock; 0 when it does not move for 300 edges
  task automatic low_period;
    logic lv;
    int   k;
    p  = 0;
    k  = 0;
    lv = lowclk;
    while (lowclk === lv && k < 300)
    begin
      @(posedge mclk);
      k++;
    end
    lv = lowclk;
    while (k < 300 && lowclk === lv && p < 300)
    begin
      @(posedge mclk);
      p++;
    end
  endtask : low_period

  task automatic t_registers;
    axi_read(32'(CFG2_ADDR), d, r);
    check_word("cfg2 reset", 32'h0, d);
    axi_read(32'(PULLUP_ADDR), d, r);
    check_word("pullup reset", 32'h0, d[7:0]);
    axi_read(32'(STAT_ADDR), d, r);
    check_bit("type select", 1'b1, d[ST_OSCILLATOR_TYPE_SELECT_BIT]);
    check_bit("rc enable", 1'b0, d[ST_RCEN_BIT]);
    axi_write(32'h3c, 32'h1, r);
    check_word("unmapped write", 32'(RESP_SLVERR), 32'(r));
    axi_read(32'h3c, d, r);
    check_word("unmapped read", 32'(RESP_SLVERR), 32'(r));
    check_word("unmapped data", 32'h0, d);
  endtask : t_registers

  task automatic t_clocks;
    count_edges(400);
    check_range("full rises", 49, 51, f);
    check_range("half rises", f / 2 - 1, f / 2 + 1, h);
    check_range("bus rises", h / 2 - 1, h / 2 + 1, b);
    low_period();
    check_range("low period", LOWCLK_HALF_CYC, LOWCLK_HALF_CYC, p);
  endtask : t_clocks

  task automatic t_gating;
    cmd_en <= 1'b0;
    repeat (10) @(posedge mclk);
    check_bit("xtal enable off", 1'b0, xen);
    count_edges(200);
    check_range("full gated", 0, 0, f + h);
    cmd_en <= 1'b1;
    repeat (10) @(posedge mclk);
    count_edges(200);
    check_range("full back", 24, 26, f);
  endtask : t_gating

  task automatic t_running_mode(input logic w, input logic bk);
    cmd_wait <= w;
    cmd_brk  <= bk;
    repeat (5) @(posedge mclk);
    axi_read(32'(STAT_ADDR), d, r);
    check_bit("wait status", w, d[ST_WAIT_BIT]);
    check_bit("break status", bk, d[ST_BREAK_BIT]);
    check_bit("xtal status", 1'b1, d[ST_XTALEN_BIT]);
    count_edges(400);
    check_range("full in mode", 49, 51, f);
    check_range("half in mode", 24, 26, h);
    low_period();
    check_range("low in mode", LOWCLK_HALF_CYC, LOWCLK_HALF_CYC, p);
    cmd_wait <= 1'b0;
    cmd_brk  <= 1'b0;
  endtask : t_running_mode

  task automatic t_stop;
    cmd_stop <= 1'b1;
    repeat (10) @(posedge mclk);
    count_edges(200);
    check_range("full in stop", 0, 0, f + h);
    low_period();
    check_range("low in stop", LOWCLK_HALF_CYC, LOWCLK_HALF_CYC, p);
    cmd_stop <= 1'b0;
    axi_write(32'(CFG2_ADDR), 32'h1, r);
    axi_read(32'(CFG2_ADDR), d, r);
    check_word("cfg2 set", 32'h1, d[7:0]);
    cmd_stop <= 1'b1;
    repeat (5) @(posedge mclk);
    low_period();
    check_range("low stopped", 0, 0, p);
    axi_read(32'(STAT_ADDR), d, r);
    check_bit("low run status", 1'b0, d[ST_LOWRUN_BIT]);
    check_bit("stop status", 1'b1, d[ST_STOP_BIT]);
    cmd_stop <= 1'b0;
    low_period();
    check_range("low resumed", LOWCLK_HALF_CYC, LOWCLK_HALF_CYC, p);
    axi_write(32'(CFG2_ADDR), 32'h0, r);
  endtask : t_stop

  task automatic t_pin_level(input logic lv, input logic e_o);
    src_run <= 1'b0;
    src_lvl <= lv;
    repeat (10) @(posedge mclk);
    check_bit("pin drive", 1'b1, pin_oe);
    check_bit("pin level", e_o, pin_o);
    check_bit("one source", 1'b1, xen ^ rcen);
    src_run <= 1'b1;
  endtask : t_pin_level

  task automatic t_rc_mode;
    type_sel <= 1'b0;
    do_reset();
    axi_read(32'(STAT_ADDR), d, r);
    check_bit("rc type", 1'b0, d[ST_OSCILLATOR_TYPE_SELECT_BIT]);
    check_bit("rc on", 1'b1, rcen);
    t_pin_level(1'b1, 1'b1);
    axi_write(32'(PULLUP_ADDR), 32'h40, r);
    ext_lvl <= 1'b1;
    repeat (10) @(posedge mclk);
    check_bit("pin released", 1'b0, pin_oe);
    check_bit("port high", 1'b1, kbi);
    ext_lvl <= 1'b0;
    repeat (10) @(posedge mclk);
    check_bit("port low", 1'b0, kbi);
    count_edges(400);
    check_range("rc full rises", 49, 51, f);
  endtask : t_rc_mode

  initial
  begin
    #5_000_000;
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    axi_req  = '0;
    type_sel = 1'b1;
    {cmd_en, cmd_stop, cmd_wait, cmd_brk} = 4'h8;
    {src_run, src_lvl, ext_lvl} = 3'h4;
    do_reset();
    t_registers();
    t_clocks();
    t_gating();
    t_running_mode(1'b1, 1'b0);
    t_running_mode(1'b0, 1'b1);
    t_stop();
    t_pin_level(1'b1, 1'b0);
    t_pin_level(1'b0, 1'b1);
    t_rc_mode();
    complete_run();
  end
endmodule : oscillator_clock_control_tb
